// >>> design/sorption_bed_normal_cycle_ctrl.sv
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ns
// What this block does
// - heatup bed gets its own heatup power, its gas gap off
// - desorb bed gets its own desorb power, its gas gap off
// - cooldown and absorb beds get no heater power in normal
// - cooldown gas gap turns on after its per-bed delay from cycle start
// - last absorb gas gap turns off its per-bed lead before cycle end
// - bed powers reapplied every N sensor rounds, editable any time
// - primary stab heater driven, refreshed every sensor round
// - primary bad: backup on from cycle start for a percent, then off
// - rotation advances when elapsed time reaches the cycle duration
// - shortened cycle time mid-cycle ends the cycle at once if passed
// - changed gas gap delays re-evaluate switch states at once
// - fault returns to startup only while auto return is enabled
// - heatup or desorb bed over temperature limit is a fault
// - storage tank pressure outside low/high limits is a fault
// - valve temperature over limit, limit chosen by sensor health
// - cold-stage regulation runs only in normal mode
// - PID at set rate with P, I, D gains on primary or backup heater
// - primary cold sensor and setpoint if good, else the secondary pair
// - regulation voltage clamped between min and max limits
// - cold stage over limit stops PID and resets its state
// - open-loop regulator separately enabled, alone or with PID
// - normal-only beds leave rotation in startup, rejoin in normal
// - normal entered by startup handoff or by go-to-normal command
module sorption_bed_normal_cycle_ctrl (
  input wire logic core_clk_in, // 250 MHz
  input wire logic resetn_in, // async, active low
  input wire logic [7:0] addr_in, // register byte address
  input wire logic [31:0] wr_data_in, // write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [31:0] rd_data_out, // read data, cycle after rd_in
  input wire logic sec_tick_in, // one-second tick pulse
  input wire logic acq_done_in, // all-sensor round done pulse
  input wire logic startup_ready_in, // startup asks for normal
  input wire sorption_cycle_pkg::sensors_s sens_in, // sensor readings
  output sorption_cycle_pkg::drive_s drive_out, // bed and stab drive
  output logic [15:0] cold_htr_primary_out, // cold-stage primary volts
  output logic [15:0] cold_htr_backup_out, // cold-stage backup volts
  output logic normal_mode_out, // high in normal state
  output logic power_apply_out // pulse: bed powers reapplied
);
  // ==================================================
  // helpers
  function automatic sorption_cycle_pkg::bed_t step(
    input sorption_cycle_pkg::bed_t i, input sorption_cycle_pkg::mask_t m,
    input logic fwd);
    sorption_cycle_pkg::bed_t j;
    sorption_cycle_pkg::bed_t r;
    logic found;
    j = i;
    r = i;
    found = 1'b0;
    for (int k = 0; k < sorption_cycle_pkg::NBEDS; k++) begin
      if (fwd) begin
        j = (j == 3'(sorption_cycle_pkg::NBEDS - 1)) ? 3'h0 : j + 3'h1;
      end else begin
        j = (j == 3'h0) ? 3'(sorption_cycle_pkg::NBEDS - 1) : j - 3'h1;
      end
      if (!found && m[j]) begin
        r = j;
        found = 1'b1;
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] clamp(input logic signed [49:0] v,
    input logic [15:0] lo, input logic [15:0] hi);
    if (v < $signed({34'h0, lo})) begin
      return lo;
    end else if (v > $signed({34'h0, hi})) begin
      return hi;
    end
    return v[15:0];
  endfunction

  // ==================================================
  // register file
  logic [15:0] cfg_q [0:sorption_cycle_pkg::CFG_WORDS-1];
  logic [31:0] rd_data_q;
  logic [5:0] idx;
  logic cmd_wr;
  assign idx = addr_in[7:2];
  assign cmd_wr = wr_in && (idx == sorption_cycle_pkg::IDX_CMD);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < int'(sorption_cycle_pkg::CFG_WORDS); i++) begin
        cfg_q[i] <= sorption_cycle_pkg::CFG_RESET;
      end
    end else if (wr_in && idx < sorption_cycle_pkg::CFG_WORDS) begin
      cfg_q[idx] <= wr_data_in[15:0];
    end
  end

  logic [15:0] ctrl;
  assign ctrl = cfg_q[sorption_cycle_pkg::IDX_CTRL];
  logic auto_en, pid_en, ol_en, stab_bad, cold_sens_bad, valve_bad;
  logic cold_htr_bad;
  assign auto_en = ctrl[sorption_cycle_pkg::CTRL_AUTO_STARTUP];
  assign pid_en = ctrl[sorption_cycle_pkg::CTRL_PID_EN];
  assign ol_en = ctrl[sorption_cycle_pkg::CTRL_OL_EN];
  assign stab_bad = ctrl[sorption_cycle_pkg::CTRL_STAB_P_BAD];
  assign cold_sens_bad = ctrl[sorption_cycle_pkg::CTRL_COLD_SENS_P_BAD];
  assign valve_bad = ctrl[sorption_cycle_pkg::CTRL_VALVE_SENS_P_BAD];
  assign cold_htr_bad = ctrl[sorption_cycle_pkg::CTRL_COLD_HTR_P_BAD];

  // ==================================================
  // mode, rotation and cycle timing
  sorption_cycle_pkg::mode_e mode_q;
  sorption_cycle_pkg::bed_t heat_q;
  logic [15:0] elapsed_q;
  logic fault_q;
  logic pid_stop_q;
  sorption_cycle_pkg::mask_t active;
  sorption_cycle_pkg::bed_t des_idx, cool_idx, last_abs;
  logic [15:0] cyc, on_dly, off_lead;
  logic cycle_end, go_normal, go_startup;

  // normal-only beds are out of the rotation outside normal
  assign active = (mode_q == sorption_cycle_pkg::ST_NORMAL) ? '1 :
    ~cfg_q[sorption_cycle_pkg::IDX_NORMAL_ONLY][5:0];
  assign des_idx = step(heat_q, active, 1'b1);
  assign cool_idx = step(des_idx, active, 1'b1);
  assign last_abs = step(heat_q, active, 1'b0);
  assign cyc = cfg_q[sorption_cycle_pkg::IDX_CYCLE];
  assign on_dly = cfg_q[sorption_cycle_pkg::IDX_ON_BASE + 6'(cool_idx)];
  assign off_lead = cfg_q[sorption_cycle_pkg::IDX_OFF_BASE + 6'(last_abs)];
  // live compare, so a shorter cycle time ends the cycle at once
  assign cycle_end = (mode_q == sorption_cycle_pkg::ST_NORMAL) &&
    (elapsed_q >= cyc);
  assign go_normal = (mode_q == sorption_cycle_pkg::ST_STARTUP) &&
    (startup_ready_in ||
     (cmd_wr && wr_data_in[sorption_cycle_pkg::CMD_GO_NORMAL]));
  assign go_startup = (mode_q == sorption_cycle_pkg::ST_NORMAL) &&
    ((fault_q && auto_en) ||
     (cmd_wr && wr_data_in[sorption_cycle_pkg::CMD_GO_STARTUP]));

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_q <= sorption_cycle_pkg::ST_STARTUP;
    end else if (go_normal) begin
      mode_q <= sorption_cycle_pkg::ST_NORMAL;
    end else if (go_startup) begin
      mode_q <= sorption_cycle_pkg::ST_STARTUP;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      heat_q <= '0;
      elapsed_q <= '0;
    end else if (go_normal || mode_q != sorption_cycle_pkg::ST_NORMAL) begin
      elapsed_q <= '0;
    end else if (cycle_end) begin
      heat_q <= last_abs;
      elapsed_q <= '0;
    end else if (sec_tick_in) begin
      elapsed_q <= elapsed_q + sorption_cycle_pkg::ONE_W;
    end
  end

  // ==================================================
  // fault checks, registered every clock
  sorption_cycle_pkg::word_t heat_temp, des_temp, valve_temp, valve_lim;
  logic fault_d;
  assign heat_temp = sens_in.bed_temp[heat_q];
  assign des_temp = sens_in.bed_temp[des_idx];
  assign valve_temp = valve_bad ? sens_in.valve_sensor_secondary :
    sens_in.valve_sensor_primary;
  assign valve_lim = valve_bad ? cfg_q[sorption_cycle_pkg::IDX_VALVE_LIM_S] :
    cfg_q[sorption_cycle_pkg::IDX_VALVE_LIM_P];
  assign fault_d =
    (heat_temp > cfg_q[sorption_cycle_pkg::IDX_BED_TEMP_LIM]) ||
    (des_temp > cfg_q[sorption_cycle_pkg::IDX_BED_TEMP_LIM]) ||
    (sens_in.tank_pressure < cfg_q[sorption_cycle_pkg::IDX_TANK_LOW]) ||
    (sens_in.tank_pressure > cfg_q[sorption_cycle_pkg::IDX_TANK_HIGH]) ||
    (valve_temp > valve_lim);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= fault_d && (mode_q == sorption_cycle_pkg::ST_NORMAL);
    end
  end

  // ==================================================
  // bed powers, gas gaps and stabilization heater
  logic [15:0] acq_cnt_q;
  logic reapply;
  logic [15:0] reapply_n;
  sorption_cycle_pkg::drive_s drive_q;
  logic [15:0] heat_pow_sel;
  logic [31:0] duty_lhs, duty_rhs;
  logic [16:0] off_point;
  logic new_cycle_q;
  assign reapply_n = cfg_q[sorption_cycle_pkg::IDX_REAPPLY_N];
  assign heat_pow_sel = cfg_q[sorption_cycle_pkg::IDX_HEAT_BASE + 6'(heat_q)];
  // a new cycle reapplies one clock late: by then heat_q names the new
  // heatup bed, so the fresh roles get their powers, not the old ones
  assign reapply = (mode_q == sorption_cycle_pkg::ST_NORMAL) &&
    ((acq_done_in && acq_cnt_q + sorption_cycle_pkg::ONE_W >= reapply_n) ||
     new_cycle_q);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      new_cycle_q <= 1'b0;
    end else begin
      new_cycle_q <= cycle_end;
    end
  end
  assign off_point = {1'b0, elapsed_q} + {1'b0, off_lead};
  assign duty_lhs = 32'(elapsed_q) * 32'(sorption_cycle_pkg::PCT_FULL);
  assign duty_rhs = 32'(cfg_q[sorption_cycle_pkg::IDX_DUTY_PCT]) * 32'(cyc);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      acq_cnt_q <= '0;
    end else if (reapply || mode_q != sorption_cycle_pkg::ST_NORMAL) begin
      acq_cnt_q <= '0;
    end else if (acq_done_in) begin
      acq_cnt_q <= acq_cnt_q + sorption_cycle_pkg::ONE_W;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive_q.bed_power <= '0;
    end else if (mode_q != sorption_cycle_pkg::ST_NORMAL) begin
      drive_q.bed_power <= '0;
    end else if (reapply) begin
      for (int b = 0; b < sorption_cycle_pkg::NBEDS; b++) begin
        if (3'(b) == heat_q) begin
          drive_q.bed_power[b] <= heat_pow_sel;
        end else if (3'(b) == des_idx) begin
          drive_q.bed_power[b] <=
            cfg_q[sorption_cycle_pkg::IDX_DES_BASE + 6'(b)];
        end else begin
          drive_q.bed_power[b] <= '0;
        end
      end
    end
  end

  // gaps follow live delays every clock, so patched delays act at once
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive_q.gap_on <= '0;
    end else begin
      for (int b = 0; b < sorption_cycle_pkg::NBEDS; b++) begin
        if (mode_q != sorption_cycle_pkg::ST_NORMAL || !active[b] ||
            3'(b) == heat_q || 3'(b) == des_idx) begin
          drive_q.gap_on[b] <= 1'b0;
        end else if (3'(b) == cool_idx) begin
          drive_q.gap_on[b] <= elapsed_q >= on_dly;
        end else if (3'(b) == last_abs) begin
          drive_q.gap_on[b] <= off_point < {1'b0, cyc};
        end else begin
          drive_q.gap_on[b] <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive_q.stab_heater_primary <= '0;
      drive_q.stab_heater_backup <= 1'b0;
    end else if (mode_q != sorption_cycle_pkg::ST_NORMAL) begin
      drive_q.stab_heater_primary <= '0;
      drive_q.stab_heater_backup <= 1'b0;
    end else begin
      if (stab_bad) begin
        drive_q.stab_heater_primary <= '0;
      end else if (acq_done_in) begin
        drive_q.stab_heater_primary <=
          cfg_q[sorption_cycle_pkg::IDX_STAB_POWER];
      end
      drive_q.stab_heater_backup <= stab_bad && !cycle_end &&
        (duty_lhs < duty_rhs);
    end
  end

  // ==================================================
  // cold-stage regulation
  logic [15:0] rate_cnt_q;
  logic reg_tick;
  logic [15:0] cold_temp, setpoint, overtemp, vmin, vmax;
  logic signed [16:0] err_d, prev_q;
  logic signed [31:0] integ_q;
  logic signed [49:0] pid_sum, pid_scaled, total;
  logic [15:0] cold_v_q;
  logic over;
  assign cold_temp = cold_sens_bad ? sens_in.cold_sensor_secondary :
    sens_in.cold_sensor_primary;
  assign setpoint = cold_sens_bad ?
    cfg_q[sorption_cycle_pkg::IDX_SETPOINT_S] :
    cfg_q[sorption_cycle_pkg::IDX_SETPOINT_P];
  assign overtemp = cold_sens_bad ?
    cfg_q[sorption_cycle_pkg::IDX_OVERTEMP_S] :
    cfg_q[sorption_cycle_pkg::IDX_OVERTEMP_P];
  assign vmin = cfg_q[sorption_cycle_pkg::IDX_VMIN];
  assign vmax = cfg_q[sorption_cycle_pkg::IDX_VMAX];
  assign over = cold_temp > overtemp;
  assign reg_tick = sec_tick_in &&
    (rate_cnt_q + sorption_cycle_pkg::ONE_W >=
     cfg_q[sorption_cycle_pkg::IDX_REG_RATE]);
  assign err_d = $signed({1'b0, setpoint}) - $signed({1'b0, cold_temp});
  assign pid_sum =
    $signed({1'b0, cfg_q[sorption_cycle_pkg::IDX_KP]}) * err_d +
    $signed({1'b0, cfg_q[sorption_cycle_pkg::IDX_KI]}) * integ_q +
    $signed({1'b0, cfg_q[sorption_cycle_pkg::IDX_KD]}) * (err_d - prev_q);
  assign pid_scaled = pid_sum >>> sorption_cycle_pkg::PID_SHIFT;
  // open-loop term stands as a plain voltage offset on top of the pid term
  assign total = (pid_en ? pid_scaled : 50'sh0) +
    (ol_en ? $signed({34'h0, cfg_q[sorption_cycle_pkg::IDX_OL_GAIN]}) :
     50'sh0);

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rate_cnt_q <= '0;
    end else if (reg_tick) begin
      rate_cnt_q <= '0;
    end else if (sec_tick_in) begin
      rate_cnt_q <= rate_cnt_q + sorption_cycle_pkg::ONE_W;
    end
  end

  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      integ_q <= '0;
      prev_q <= '0;
      cold_v_q <= '0;
      pid_stop_q <= 1'b0;
    end else if (mode_q != sorption_cycle_pkg::ST_NORMAL ||
                 !(pid_en || ol_en)) begin
      cold_v_q <= '0;
    end else if (over) begin
      integ_q <= '0;
      prev_q <= '0;
      cold_v_q <= '0;
      pid_stop_q <= 1'b1;
    end else if (reg_tick) begin
      pid_stop_q <= 1'b0;
      if (pid_en) begin
        integ_q <= integ_q + 32'(err_d);
        prev_q <= err_d;
      end
      cold_v_q <= clamp(total, vmin, vmax);
    end
  end

  // ==================================================
  // read path and outputs
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_data_q <= '0;
    end else if (!rd_in) begin
      rd_data_q <= '0;
    end else if (idx < sorption_cycle_pkg::CFG_WORDS) begin
      rd_data_q <= {16'h0000, cfg_q[idx]};
    end else if (idx == sorption_cycle_pkg::IDX_STATUS) begin
      rd_data_q <= {26'h0, pid_stop_q, fault_q, heat_q,
        mode_q == sorption_cycle_pkg::ST_NORMAL};
    end else if (idx == sorption_cycle_pkg::IDX_ELAPSED) begin
      rd_data_q <= {16'h0000, elapsed_q};
    end else begin
      rd_data_q <= '0;
    end
  end

  logic apply_q, normal_q;
  logic [15:0] cold_p_q, cold_b_q;
  always_ff @(posedge core_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      apply_q <= 1'b0;
      normal_q <= 1'b0;
      cold_p_q <= '0;
      cold_b_q <= '0;
    end else begin
      apply_q <= reapply;
      normal_q <= mode_q == sorption_cycle_pkg::ST_NORMAL;
      cold_p_q <= cold_htr_bad ? 16'h0000 : cold_v_q;
      cold_b_q <= cold_htr_bad ? cold_v_q : 16'h0000;
    end
  end

  assign rd_data_out = rd_data_q;
  assign drive_out = drive_q;
  assign power_apply_out = apply_q;
  assign normal_mode_out = normal_q;
  assign cold_htr_primary_out = cold_p_q;
  assign cold_htr_backup_out = cold_b_q;

  // ==================================================
  // assertions
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_fault_armed;
    mode_q == sorption_cycle_pkg::ST_NORMAL && fault_q && auto_en;
  endsequence
  sequence s_in_startup;
    mode_q == sorption_cycle_pkg::ST_STARTUP;
  endsequence

  property p_fault_exit;
    s_fault_armed |=> s_in_startup;
  endproperty
  a_fault_exit: assert property (p_fault_exit)
    else $error("fault with auto return did not leave normal");

  property p_stay_without_auto;
    mode_q == sorption_cycle_pkg::ST_NORMAL && !auto_en && !cmd_wr
      |=> mode_q == sorption_cycle_pkg::ST_NORMAL;
  endproperty
  a_stay_without_auto: assert property (p_stay_without_auto)
    else $error("normal left without auto return enabled");

  property p_cycle_advance;
    cycle_end |=> elapsed_q == 16'h0000 && heat_q == $past(last_abs);
  endproperty
  a_cycle_advance: assert property (p_cycle_advance)
    else $error("rotation did not advance at cycle end");

  property p_heat_power;
    reapply |=> drive_q.bed_power[$past(heat_q)] == $past(heat_pow_sel);
  endproperty
  a_heat_power: assert property (p_heat_power)
    else $error("heatup bed power wrong after reapply");

  property p_idle_unpowered;
    reapply && cool_idx != heat_q
      |=> drive_q.bed_power[$past(cool_idx)] == 16'h0000;
  endproperty
  a_idle_unpowered: assert property (p_idle_unpowered)
    else $error("cooldown bed powered");

  property p_heat_gap_off;
    mode_q == sorption_cycle_pkg::ST_NORMAL |=> !drive_q.gap_on[$past(heat_q)];
  endproperty
  a_heat_gap_off: assert property (p_heat_gap_off)
    else $error("heatup gas gap on");

  property p_clamp;
    cold_v_q != 16'h0000 && vmin <= vmax
      |-> cold_v_q >= vmin && cold_v_q <= vmax;
  endproperty
  a_clamp: assert property (p_clamp)
    else $error("regulation voltage outside limits");

  property p_suspend;
    s_in_startup ##1 s_in_startup |-> cold_v_q == 16'h0000;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("regulation active outside normal");

  property p_normal_only;
    s_in_startup |-> (active & cfg_q[sorption_cycle_pkg::IDX_NORMAL_ONLY][5:0])
      == 6'h00;
  endproperty
  a_normal_only: assert property (p_normal_only)
    else $error("normal-only bed in startup rotation");

  property p_stab_refresh;
    mode_q == sorption_cycle_pkg::ST_NORMAL && acq_done_in && !stab_bad &&
      !go_startup
      |=> drive_q.stab_heater_primary ==
        $past(cfg_q[sorption_cycle_pkg::IDX_STAB_POWER]);
  endproperty
  a_stab_refresh: assert property (p_stab_refresh)
    else $error("stabilization heater not refreshed");
endmodule // sorption_bed_normal_cycle_ctrl

// >>> pkg/sorption_cycle_pkg.sv
package sorption_cycle_pkg;
  // ==================================================
  // sizes
  localparam int NBEDS = 6;
  localparam int BED_W = 3;
  localparam int ADDR_W = 8;
  localparam int RD_W = 32;
  localparam int PID_SHIFT = 8;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [15:0] CFG_RESET = 16'h0000;
  localparam logic [15:0] ONE_W = 16'h0001;

  typedef logic [15:0] word_t;
  typedef logic [BED_W-1:0] bed_t;
  typedef logic [NBEDS-1:0] mask_t;
  typedef enum logic {ST_STARTUP, ST_NORMAL} mode_e;

  // ==================================================
  // register word indexes (byte address = index * 4)
  localparam logic [5:0] IDX_CTRL = 6'h00;
  localparam logic [5:0] IDX_CYCLE = 6'h01;
  localparam logic [5:0] IDX_REAPPLY_N = 6'h02;
  localparam logic [5:0] IDX_STAB_POWER = 6'h03;
  localparam logic [5:0] IDX_DUTY_PCT = 6'h04;
  localparam logic [5:0] IDX_BED_TEMP_LIM = 6'h05;
  localparam logic [5:0] IDX_TANK_LOW = 6'h06;
  localparam logic [5:0] IDX_TANK_HIGH = 6'h07;
  localparam logic [5:0] IDX_VALVE_LIM_P = 6'h08;
  localparam logic [5:0] IDX_VALVE_LIM_S = 6'h09;
  localparam logic [5:0] IDX_SETPOINT_P = 6'h0a;
  localparam logic [5:0] IDX_SETPOINT_S = 6'h0b;
  localparam logic [5:0] IDX_KP = 6'h0c;
  localparam logic [5:0] IDX_KI = 6'h0d;
  localparam logic [5:0] IDX_KD = 6'h0e;
  localparam logic [5:0] IDX_REG_RATE = 6'h0f;
  localparam logic [5:0] IDX_VMIN = 6'h10;
  localparam logic [5:0] IDX_VMAX = 6'h11;
  localparam logic [5:0] IDX_OVERTEMP_P = 6'h12;
  localparam logic [5:0] IDX_OVERTEMP_S = 6'h13;
  localparam logic [5:0] IDX_OL_GAIN = 6'h14;
  localparam logic [5:0] IDX_OL_N = 6'h15;
  localparam logic [5:0] IDX_NORMAL_ONLY = 6'h16;
  localparam logic [5:0] IDX_HEAT_BASE = 6'h20;
  localparam logic [5:0] IDX_DES_BASE = 6'h26;
  localparam logic [5:0] IDX_ON_BASE = 6'h2c;
  localparam logic [5:0] IDX_OFF_BASE = 6'h32;
  localparam logic [5:0] CFG_WORDS = 6'h38;
  localparam logic [5:0] IDX_STATUS = 6'h38;
  localparam logic [5:0] IDX_ELAPSED = 6'h39;
  localparam logic [5:0] IDX_CMD = 6'h3a;

  // ==================================================
  // control and command bits
  localparam int CTRL_AUTO_STARTUP = 0;
  localparam int CTRL_PID_EN = 1;
  localparam int CTRL_OL_EN = 2;
  localparam int CTRL_STAB_P_BAD = 3;
  localparam int CTRL_COLD_SENS_P_BAD = 4;
  localparam int CTRL_VALVE_SENS_P_BAD = 5;
  localparam int CTRL_COLD_HTR_P_BAD = 6;
  localparam int CMD_GO_NORMAL = 0;
  localparam int CMD_GO_STARTUP = 1;

  // ==================================================
  // carriers
  typedef struct packed {
    word_t [NBEDS-1:0] bed_temp;
    word_t tank_pressure;
    word_t valve_sensor_primary;
    word_t valve_sensor_secondary;
    word_t cold_sensor_primary;
    word_t cold_sensor_secondary;
  } sensors_s;

  typedef struct packed {
    word_t [NBEDS-1:0] bed_power;
    mask_t gap_on;
    word_t stab_heater_primary;
    logic stab_heater_backup;
  } drive_s;
endpackage

// >>> test/cooler_plant_model.sv
`timescale 1ns/1ns
// ==================================================
// plant stand-in: steady readings, storage tank leak on demand
module cooler_plant_model (
  input wire logic leak_in, // drop tank pressure
  input wire sorption_cycle_pkg::drive_s drive_in, // heater drive
  output sorption_cycle_pkg::sensors_s sens_out // sensor readings
);
  always_comb begin
    sens_out = '0;
    // leak goes well under the low limit the bench sets
    sens_out.tank_pressure = leak_in ? 16'h0010 : 16'h0800;
    for (int b = 0; b < 6; b++) begin
      // warms a little with power, stays under the bed limit
      sens_out.bed_temp[b] = 16'h0100 + {8'h00, drive_in.bed_power[b][7:0]};
    end
  end
endmodule // cooler_plant_model

// >>> test/test_sorption_bed_normal_cycle_ctrl.sv
`timescale 1ns/1ns
`define CHK(a, b) chk((a) === (b), `__LINE__)
module test_sorption_bed_normal_cycle_ctrl;
  logic clk = 0, resetn = 0, wr = 0, rd = 0, sec = 0, acq = 0, leak = 0;
  logic rdy = 0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, got;
  logic nrm, pap;
  logic [15:0] chp, chb;
  sorption_cycle_pkg::sensors_s sens;
  sorption_cycle_pkg::drive_s drv;
  int error_cnt = 0, checks = 0;
  int apply_cnt = 0;
  initial forever #2 clk = ~clk;
  sorption_bed_normal_cycle_ctrl i_sorption_bed_normal_cycle_ctrl (
    .core_clk_in(clk), .resetn_in(resetn), .addr_in(addr),
    .wr_data_in(wdat), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat),
    .sec_tick_in(sec), .acq_done_in(acq), .startup_ready_in(rdy),
    .sens_in(sens), .drive_out(drv), .cold_htr_primary_out(chp),
    .cold_htr_backup_out(chb), .normal_mode_out(nrm),
    .power_apply_out(pap));
  cooler_plant_model i_cooler_plant_model (
    .leak_in(leak), .drive_in(drv), .sens_out(sens));
  // reload pulses counted away from the edge that launches them
  always @(negedge clk) begin
    if (pap === 1'b1) apply_cnt++;
  end
  // ==================================================
  // bus and compare helpers
  task automatic chk(input bit ok, input int ln);
    checks++;
    if (!ok) begin
      error_cnt++;
      $display("Error at %0t: mismatch at line %0d", $time, ln);
    end
  endtask
  task automatic wreg(input logic [5:0] idx, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= {idx, 2'h0};
    wdat <= {16'h0000, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [5:0] idx);
    @(posedge clk);
    rd <= 1'b1;
    addr <= {idx, 2'h0};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    got = rdat;
  endtask
  // pulses apart so each is a clean one-cycle event
  task automatic pulse(input bit s, input int n);
    repeat (n) begin
      @(posedge clk);
      if (s) sec <= 1'b1;
      else acq <= 1'b1;
      @(posedge clk);
      sec <= 1'b0;
      acq <= 1'b0;
    end
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // ==================================================
  // tests
  initial begin
    #20000;
    error_cnt++;
    give_verdict;
  end
  initial begin
    repeat (4) @(posedge clk);
    `CHK(drv, '0);
    resetn <= 1'b1;
    for (int b = 0; b < 6; b++) begin
      wreg(sorption_cycle_pkg::IDX_HEAT_BASE + 6'(b), 16'h0010 + 16'(b));
      wreg(sorption_cycle_pkg::IDX_DES_BASE + 6'(b), 16'h0020 + 16'(b));
    end
    wreg(sorption_cycle_pkg::IDX_CYCLE, 16'h0004);
    wreg(sorption_cycle_pkg::IDX_STAB_POWER, 16'h0033);
    wreg(sorption_cycle_pkg::IDX_BED_TEMP_LIM, 16'h0400);
    wreg(sorption_cycle_pkg::IDX_TANK_LOW, 16'h0100);
    wreg(sorption_cycle_pkg::IDX_TANK_HIGH, 16'h0f00);
    wreg(sorption_cycle_pkg::IDX_VALVE_LIM_P, 16'h0100);
    wreg(sorption_cycle_pkg::IDX_VALVE_LIM_S, 16'h0100);
    wreg(sorption_cycle_pkg::IDX_VMAX, 16'h0050);
    wreg(sorption_cycle_pkg::IDX_OL_GAIN, 16'h0080);
    wreg(sorption_cycle_pkg::IDX_ON_BASE + 6'h02, 16'h0002);
    wreg(sorption_cycle_pkg::IDX_OFF_BASE + 6'h05, 16'h0001);
    wreg(sorption_cycle_pkg::IDX_DUTY_PCT, 16'h0032);
    wreg(sorption_cycle_pkg::IDX_CTRL, 16'h0004);
    rreg(sorption_cycle_pkg::IDX_CYCLE);
    `CHK(got, 32'h0000_0004);
    rreg(6'h3f);
    `CHK(got, 32'h0000_0000);
    wreg(sorption_cycle_pkg::IDX_CMD, 16'h0001);
    pulse(1'b0, 1);
    `CHK(nrm, 1'b1);
    `CHK(drv.stab_heater_primary, 16'h0033);
    `CHK(drv.bed_power[0], 16'h0010);
    `CHK(drv.bed_power[1], 16'h0021);
    `CHK(drv.bed_power[3], 16'h0000);
    `CHK(drv.gap_on[1:0], 2'h0);
    `CHK(drv.gap_on[5:2], 4'he);
    $display("test powers done");
    pulse(1'b1, 3);
    `CHK(drv.gap_on[2], 1'b1);
    `CHK(drv.gap_on[5], 1'b0);
    `CHK(chp, 16'h0050);
    `CHK(chb, 16'h0000);
    wreg(sorption_cycle_pkg::IDX_ON_BASE + 6'h02, 16'h0005);
    pulse(1'b1, 0);
    `CHK(drv.gap_on[2], 1'b0);
    wreg(sorption_cycle_pkg::IDX_CYCLE, 16'h0002);
    rreg(sorption_cycle_pkg::IDX_ELAPSED);
    `CHK(got, 32'h0000_0000);
    pulse(1'b0, 1);
    `CHK(drv.bed_power[5], 16'h0015);
    `CHK(drv.bed_power[0], 16'h0020);
    `CHK(drv.bed_power[1], 16'h0000);
    $display("test rotation done");
    wreg(sorption_cycle_pkg::IDX_CTRL, 16'h004c);
    pulse(1'b1, 0);
    `CHK(drv.stab_heater_backup, 1'b1);
    `CHK(drv.stab_heater_primary, 16'h0000);
    `CHK(chb, 16'h0050);
    `CHK(chp, 16'h0000);
    pulse(1'b1, 1);
    `CHK(drv.stab_heater_backup, 1'b0);
    $display("test backup heaters done");
    @(posedge clk);
    leak <= 1'b1;
    pulse(1'b0, 1);
    `CHK(nrm, 1'b1);
    wreg(sorption_cycle_pkg::IDX_CTRL, 16'h0001);
    pulse(1'b0, 1);
    `CHK(nrm, 1'b0);
    `CHK(drv.bed_power[5], 16'h0000);
    `CHK(apply_cnt, 4);
    $display("test fault exit done");
    @(posedge clk);
    leak <= 1'b0;
    rdy <= 1'b1;
    @(posedge clk);
    rdy <= 1'b0;
    rreg(sorption_cycle_pkg::IDX_STATUS);
    `CHK(got, 32'h0000_000b);
    `CHK(nrm, 1'b1);
    $display("test reentry done");
    give_verdict;
  end
endmodule // test_sorption_bed_normal_cycle_ctrl
